//--- logic/unlock_seq_pkg.sv
// shared constants for the write-unlock command sequencer
package unlock_seq_pkg;
	localparam int          ADDR_W         = 19;
	localparam int          CMP_W          = 16;
	localparam logic [15:0] UNLOCK_ADDR_A  = 16'h5555;
	localparam logic [15:0] UNLOCK_ADDR_B  = 16'h2AAA;
	localparam logic [7:0]  UNLOCK_DATA_A  = 8'hAA;
	localparam logic [7:0]  UNLOCK_DATA_B  = 8'h55;
	localparam logic [7:0]  CMD_PROGRAM    = 8'hA0;
	localparam logic [7:0]  CMD_ERASE_SET  = 8'h80;
	localparam logic [7:0]  CMD_BLOCK_A    = 8'h30;
	localparam logic [7:0]  CMD_BLOCK_B    = 8'h50;
	localparam logic [7:0]  CMD_CHIP       = 8'h10;
	localparam logic [7:0]  CMD_ID_ENTRY   = 8'h90;
	localparam logic [7:0]  CMD_ID_EXIT    = 8'hF0;
	localparam logic [1:0]  ID_SEL_MANUF   = 2'h0;
	localparam logic [1:0]  ID_SEL_DEVICE  = 2'h1;
	localparam logic [1:0]  ID_SEL_CONT    = 2'h3;
	localparam int          POLL_BIT       = 7;
	localparam int          TOGGLE_BIT     = 6;
	localparam int          CLOCK_NS       = 100;
	localparam int          READ_CYCLE_NS  = 270;
	// longest time, rounded down, never below one cycle
	localparam int          ABORT_CYCLES   = (READ_CYCLE_NS / CLOCK_NS) < 1 ? 1
	                                         : (READ_CYCLE_NS / CLOCK_NS);

	typedef enum logic [1:0] {
		OP_PROGRAM = 2'b00,
		OP_BLOCK   = 2'b01,
		OP_CHIP    = 2'b10
	} op_kind_t;

	typedef enum logic [2:0] {
		ST_READ    = 3'b000,
		ST_UNLK1   = 3'b001,
		ST_UNLK2   = 3'b010,
		ST_PROGRAM = 3'b011,
		ST_ERASE   = 3'b100,
		ST_EUNLK1  = 3'b101,
		ST_EUNLK2  = 3'b110
	} seq_state_t;
endpackage : unlock_seq_pkg

//--- logic/status_reader.sv
// read data path: array data, identification codes and busy status bits
`timescale 1ns/100ps
module status_reader (
	input  wire logic                         CLOCK,
	input  wire logic                         NRST,
	input  wire logic                         rd,
	input  wire logic [1:0]                   rd_sel,
	input  wire logic [7:0]                   array_data,
	input  wire logic                         busy,
	input  wire logic                         erasing,
	input  wire logic [7:0]                   prog_value,
	input  wire logic                         id_mode,
	input  wire logic [7:0]                   manuf_id,
	input  wire logic [7:0]                   device_id,
	input  wire logic [7:0]                   cont_id,
	output logic      [7:0]                   read_data,
	output logic                              read_valid
);
	import unlock_seq_pkg::*;

	logic       toggle_q;
	logic [7:0] data_d;

	always_ff @(posedge CLOCK) begin
		if (!NRST)
			toggle_q <= 1'b0;
		else if (rd && busy)
			toggle_q <= ~toggle_q;
		else if (!busy)
			toggle_q <= 1'b0;
	end

	always_comb begin
		data_d = array_data;
		if (busy) begin
			data_d[POLL_BIT]   = erasing ? 1'b0 : ~prog_value[POLL_BIT];
			data_d[TOGGLE_BIT] = toggle_q;
		end else if (id_mode) begin
			case (rd_sel)
				ID_SEL_MANUF:  data_d = manuf_id;
				ID_SEL_DEVICE: data_d = device_id;
				ID_SEL_CONT:   data_d = cont_id;
				default:       data_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			read_data  <= 8'h00;
			read_valid <= 1'b0;
		end else begin
			read_valid <= rd;
			if (rd)
				read_data <= data_d;
		end
	end
endmodule : status_reader

//--- logic/flash_write_unlock_sequencer.sv
// write-unlock command decoder for the byte-wide flash array
`timescale 1ns/100ps
module flash_write_unlock_sequencer #(
	parameter int          ADDR_WIDTH = unlock_seq_pkg::ADDR_W,
	parameter logic [7:0]  MANUF_ID   = 8'hA5, // arbitrary value
	parameter logic [7:0]  DEVICE_ID  = 8'h5A, // arbitrary value
	parameter logic [7:0]  CONT_ID    = 8'h3C  // arbitrary value
) (
	input  wire logic                         CLOCK,
	input  wire logic                         NRST,
	input  wire logic                         BUS_WR,
	input  wire logic                         BUS_IN_RANGE,
	input  wire logic [ADDR_WIDTH-1:0]        BUS_ADDR,
	input  wire logic [7:0]                   BUS_DATA,
	input  wire logic                         MUX_WE_N,
	input  wire logic                         MUX_OE_N,
	input  wire logic [ADDR_WIDTH-1:0]        MUX_ADDR,
	input  wire logic [7:0]                   MUX_DATA,
	input  wire logic                         RD,
	input  wire logic [1:0]                   RD_SEL,
	input  wire logic [7:0]                   ARRAY_DATA,
	input  wire logic                         OP_DONE,
	output logic                              OP_START,
	output unlock_seq_pkg::op_kind_t          OP_KIND,
	output logic      [ADDR_WIDTH-1:0]        OP_ADDR,
	output logic      [7:0]                   OP_VALUE,
	output logic                              BUSY,
	output logic                              ID_MODE,
	output logic      [7:0]                   READ_DATA,
	output logic                              READ_VALID
);
	import unlock_seq_pkg::*;

	// block addresses need at least one bit above the compared offset field
	if (ADDR_WIDTH < CMP_W + 1) begin : g_width_check
		$error("address width too small for unlock offsets");
	end

	// two-flop synchronisers for the multiplexed programming port
	logic                  we_s1_q, we_s2_q, we_s3_q;
	logic                  oe_s1_q, oe_s2_q;
	logic [ADDR_WIDTH-1:0] ma_s1_q, ma_s2_q;
	logic [7:0]            md_s1_q, md_s2_q;

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			we_s1_q <= 1'b1;
			we_s2_q <= 1'b1;
			we_s3_q <= 1'b1;
			oe_s1_q <= 1'b1;
			oe_s2_q <= 1'b1;
			ma_s1_q <= '0;
			ma_s2_q <= '0;
			md_s1_q <= 8'h00;
			md_s2_q <= 8'h00;
		end else begin
			we_s1_q <= MUX_WE_N;
			we_s2_q <= we_s1_q;
			we_s3_q <= we_s2_q;
			oe_s1_q <= MUX_OE_N;
			oe_s2_q <= oe_s1_q;
			ma_s1_q <= MUX_ADDR;
			ma_s2_q <= ma_s1_q;
			md_s1_q <= MUX_DATA;
			md_s2_q <= md_s1_q;
		end
	end

	// address and data travel through the same flop depth as the strobe,
	// so the values seen at the rising edge belong to that write
	logic mux_wr;
	assign mux_wr = we_s2_q && !we_s3_q && oe_s2_q;

	// bus port wins a coincident cycle; the pair cannot both be live in practice
	logic                  wr;
	logic                  wr_mux;
	logic [ADDR_WIDTH-1:0] wr_addr;
	logic [7:0]            wr_data;

	always_comb begin
		wr      = 1'b0;
		wr_mux  = 1'b0;
		wr_addr = ma_s2_q;
		wr_data = md_s2_q;
		if (BUS_WR && BUS_IN_RANGE) begin
			wr      = 1'b1;
			wr_addr = BUS_ADDR;
			wr_data = BUS_DATA;
		end else if (mux_wr) begin
			wr     = 1'b1;
			wr_mux = 1'b1;
		end
	end

	function automatic logic hit(input logic [ADDR_WIDTH-1:0] a, input logic [15:0] off,
			input logic [7:0] d, input logic [7:0] val);
		hit = (a[CMP_W-1:0] == off) && (d == val);
	endfunction : hit

	seq_state_t state_q, state_d;
	logic       start_d;
	op_kind_t   kind_d;
	logic       id_set, id_clr;

	always_comb begin
		state_d = state_q;
		start_d = 1'b0;
		kind_d  = OP_PROGRAM;
		id_set  = 1'b0;
		id_clr  = 1'b0;
		// only a CMD_ID_EXIT write in ST_READ bypasses the unlock prefix, and nothing switches it off
		if (wr && !BUSY) begin
			state_d = ST_READ;
			case (state_q)
				ST_READ: begin
					if (wr_data == CMD_ID_EXIT)
						id_clr = 1'b1;
					else if (hit(wr_addr, UNLOCK_ADDR_A, wr_data, UNLOCK_DATA_A))
						state_d = ST_UNLK1;
				end
				ST_UNLK1: begin
					if (hit(wr_addr, UNLOCK_ADDR_B, wr_data, UNLOCK_DATA_B))
						state_d = ST_UNLK2;
				end
				ST_UNLK2: begin
					if (hit(wr_addr, UNLOCK_ADDR_A, wr_data, CMD_PROGRAM))
						state_d = ST_PROGRAM;
					else if (hit(wr_addr, UNLOCK_ADDR_A, wr_data, CMD_ERASE_SET))
						state_d = ST_ERASE;
					else if (hit(wr_addr, UNLOCK_ADDR_A, wr_data, CMD_ID_ENTRY))
						id_set = 1'b1;
					else if (hit(wr_addr, UNLOCK_ADDR_A, wr_data, CMD_ID_EXIT))
						id_clr = 1'b1;
				end
				ST_PROGRAM: begin
					start_d = 1'b1;
					kind_d  = OP_PROGRAM;
				end
				ST_ERASE: begin
					if (hit(wr_addr, UNLOCK_ADDR_A, wr_data, UNLOCK_DATA_A))
						state_d = ST_EUNLK1;
				end
				ST_EUNLK1: begin
					if (hit(wr_addr, UNLOCK_ADDR_B, wr_data, UNLOCK_DATA_B))
						state_d = ST_EUNLK2;
				end
				ST_EUNLK2: begin
					if (wr_data == CMD_BLOCK_A || wr_data == CMD_BLOCK_B) begin
						start_d = 1'b1;
						kind_d  = OP_BLOCK;
					end else if (wr_mux && hit(wr_addr, UNLOCK_ADDR_A, wr_data, CMD_CHIP)) begin
						start_d = 1'b1;
						kind_d  = OP_CHIP;
					end
				end
				default: state_d = ST_READ;
			endcase
		end
	end

	// mismatch drops to read mode on the next edge, well inside ABORT_CYCLES
	always_ff @(posedge CLOCK) begin
		if (!NRST)
			state_q <= ST_READ;
		else
			state_q <= state_d;
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST)
			ID_MODE <= 1'b0;
		else if (id_set)
			ID_MODE <= 1'b1;
		else if (id_clr)
			ID_MODE <= 1'b0;
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			OP_START <= 1'b0;
			OP_KIND  <= OP_PROGRAM;
			OP_ADDR  <= '0;
			OP_VALUE <= 8'h00;
		end else begin
			OP_START <= start_d;
			if (start_d) begin
				OP_KIND  <= kind_d;
				OP_ADDR  <= wr_addr;
				OP_VALUE <= wr_data;
			end
		end
	end

	// a done arriving with a new start cannot happen: starts need !BUSY
	always_ff @(posedge CLOCK) begin
		if (!NRST)
			BUSY <= 1'b0;
		else if (start_d)
			BUSY <= 1'b1;
		else if (OP_DONE)
			BUSY <= 1'b0;
	end

	status_reader u_status_reader (
		.CLOCK      (CLOCK),
		.NRST       (NRST),
		.rd         (RD),
		.rd_sel     (RD_SEL),
		.array_data (ARRAY_DATA),
		.busy       (BUSY),
		.erasing    (OP_KIND != OP_PROGRAM),
		.prog_value (OP_VALUE),
		.id_mode    (ID_MODE),
		.manuf_id   (MANUF_ID),
		.device_id  (DEVICE_ID),
		.cont_id    (CONT_ID),
		.read_data  (READ_DATA),
		.read_valid (READ_VALID)
	);
endmodule : flash_write_unlock_sequencer

//--- tb/unlock_seq_chk.sv
// port assertions for the write-unlock sequencer
`timescale 1ns/100ps
module unlock_seq_chk
	import unlock_seq_pkg::*;
(
	input wire logic	CLOCK,
	input wire logic	NRST,
	input wire logic	RD,
	input wire logic [7:0]	ARRAY_DATA,
	input wire logic	OP_DONE,
	input wire logic	OP_START,
	input wire op_kind_t	OP_KIND,
	input wire logic [7:0]	OP_VALUE,
	input wire logic	BUSY,
	input wire logic	ID_MODE,
	input wire logic [7:0]	READ_DATA,
	input wire logic	READ_VALID
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	a_start_busy: assert property (OP_START |-> BUSY && !$past(BUSY))
		else $error("start without fresh busy");
	a_busy_ignore: assert property (BUSY && !OP_DONE |=> !OP_START)
		else $error("start while busy");
	a_done_clears: assert property (BUSY && OP_DONE |=> !BUSY)
		else $error("busy kept after done");
	a_array_read: assert property (RD && !BUSY && !ID_MODE |=>
		READ_VALID && READ_DATA == $past(ARRAY_DATA))
		else $error("idle read not array data");
	a_poll_prog: assert property (RD && BUSY && !OP_DONE && OP_KIND == OP_PROGRAM |=>
		READ_DATA[POLL_BIT] == !OP_VALUE[POLL_BIT])
		else $error("program poll bit wrong");
	a_poll_erase: assert property (RD && BUSY && !OP_DONE && OP_KIND != OP_PROGRAM |=>
		!READ_DATA[POLL_BIT])
		else $error("erase poll bit wrong");
	a_toggle_flip: assert property ((RD && BUSY && !OP_DONE) ##1 !RD ##1 (RD && BUSY && !OP_DONE)
		|=> READ_DATA[TOGGLE_BIT] != $past(READ_DATA[TOGGLE_BIT], 2))
		else $error("toggle bit stuck");
	a_kind_stable: assert property (BUSY |=> $stable(OP_KIND) && $stable(OP_VALUE))
		else $error("operation changed while busy");
endmodule : unlock_seq_chk

bind flash_write_unlock_sequencer unlock_seq_chk u_chk (.CLOCK(CLOCK), .NRST(NRST), .RD(RD),
	.ARRAY_DATA(ARRAY_DATA), .OP_DONE(OP_DONE), .OP_START(OP_START), .OP_KIND(OP_KIND),
	.OP_VALUE(OP_VALUE), .BUSY(BUSY), .ID_MODE(ID_MODE), .READ_DATA(READ_DATA),
	.READ_VALID(READ_VALID));

//--- tb/mux_programmer.sv
// programmer model driving the multiplexed write port
`timescale 1ns/100ps
module mux_programmer (
	input wire logic	clk,
	output logic		we_n,
	output logic		oe_n,
	output logic [18:0]	addr,
	output logic [7:0]	data
);
	initial begin
		we_n = 1'b1;
		oe_n = 1'b1;
		addr = '0;
		data = '0;
	end
	// strobe period 800 ns: four cycles low, four high
	task automatic wr(input logic [18:0] a, input logic [7:0] d, input logic oe);
		@(posedge clk) #1;
		addr = a;
		data = d;
		oe_n = oe;
		we_n = 1'b0;
		repeat (4) @(posedge clk);
		#1 we_n = 1'b1;
		// the next call's own edge wait completes the fourth high cycle
		repeat (3) @(posedge clk);
		// hold over: pins stop showing the value
		#1 addr = ~a;
		data = ~d;
		oe_n = 1'b1;
	endtask : wr
endmodule : mux_programmer

//--- tb/flash_write_unlock_sequencer_bench.sv
// self-checking bench for the write-unlock sequencer
`timescale 1ns/100ps
module flash_write_unlock_sequencer_bench;
	import unlock_seq_pkg::*;
	logic		CLOCK, NRST, BUS_WR, BUS_IN_RANGE, RD, OP_DONE, OP_START, BUSY;
	logic		ID_MODE, READ_VALID, MUX_WE_N, MUX_OE_N;
	logic [18:0]	BUS_ADDR, MUX_ADDR, OP_ADDR;
	logic [7:0]	BUS_DATA, MUX_DATA, ARRAY_DATA, OP_VALUE, READ_DATA;
	logic [1:0]	RD_SEL;
	op_kind_t	OP_KIND;
	int		err_count = 0;
	int		tests_run = 0;
	flash_write_unlock_sequencer #(
		.MANUF_ID(8'h6B), .DEVICE_ID(8'h4E), .CONT_ID(8'h2D)) dut ( // arbitrary ids
		.CLOCK(CLOCK), .NRST(NRST), .BUS_WR(BUS_WR), .BUS_IN_RANGE(BUS_IN_RANGE),
		.BUS_ADDR(BUS_ADDR), .BUS_DATA(BUS_DATA), .MUX_WE_N(MUX_WE_N), .MUX_OE_N(MUX_OE_N),
		.MUX_ADDR(MUX_ADDR), .MUX_DATA(MUX_DATA), .RD(RD), .RD_SEL(RD_SEL),
		.ARRAY_DATA(ARRAY_DATA), .OP_DONE(OP_DONE), .OP_START(OP_START), .OP_KIND(OP_KIND),
		.OP_ADDR(OP_ADDR), .OP_VALUE(OP_VALUE), .BUSY(BUSY), .ID_MODE(ID_MODE),
		.READ_DATA(READ_DATA), .READ_VALID(READ_VALID));
	mux_programmer prog (.clk(CLOCK), .we_n(MUX_WE_N), .oe_n(MUX_OE_N), .addr(MUX_ADDR),
		.data(MUX_DATA));
	initial begin
		CLOCK = 1'b0;
		forever #50 CLOCK = ~CLOCK;
	end
	task chk(input logic [18:0] got, input logic [18:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wrap_up;
		$display("errors %0d checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up
	task bw(input logic [18:0] a, input logic [7:0] d);
		@(posedge CLOCK) #1;
		BUS_WR = 1'b1;
		BUS_ADDR = a;
		BUS_DATA = d;
	endtask : bw
	task idle;
		@(posedge CLOCK) #1;
		BUS_WR = 1'b0;
	endtask : idle
	task unl;
		bw(19'h05555, 8'hAA);
		bw(19'h02AAA, 8'h55);
	endtask : unl
	task rd(input logic [1:0] s);
		@(posedge CLOCK) #1;
		RD = 1'b1;
		RD_SEL = s;
		@(posedge CLOCK) #1;
		RD = 1'b0;
	endtask : rd
	task done_op;
		@(posedge CLOCK) #1;
		OP_DONE = 1'b1;
		@(posedge CLOCK) #1;
		OP_DONE = 1'b0;
		chk(BUSY, 0);
	endtask : done_op
	task t_program;
		unl;
		bw(19'h05555, CMD_PROGRAM);
		bw(19'h41234, 8'hC3);
		idle;
		chk(OP_START, 1);
		chk(OP_ADDR, 19'h41234);
		chk(OP_VALUE, 8'hC3);
		rd(0);
		chk(READ_DATA[7:6], 2'b00);
		rd(0);
		chk(READ_DATA[7:6], 2'b01);
		unl;
		bw(19'h05555, CMD_PROGRAM);
		bw(19'h00011, 8'h22);
		idle;
		chk(OP_VALUE, 8'hC3);
		done_op;
		rd(0);
		chk(READ_DATA, 8'h3C);
	endtask : t_program
	task t_erase;
		for (int i = 0; i < 2; i++) begin
			unl;
			bw(19'h05555, CMD_ERASE_SET);
			unl;
			bw(19'h30007, i ? CMD_BLOCK_B : CMD_BLOCK_A);
			idle;
			chk(OP_KIND, OP_BLOCK);
			chk(OP_ADDR, 19'h30007);
			rd(0);
			chk(READ_DATA[7], 0);
			done_op;
		end
	endtask : t_erase
	task t_chip;
		unl;
		bw(19'h05555, CMD_ERASE_SET);
		unl;
		bw(19'h05555, CMD_CHIP);
		idle;
		chk(BUSY, 0);
		prog.wr(19'h05555, 8'hAA, 1);
		prog.wr(19'h02AAA, 8'h55, 1);
		prog.wr(19'h05555, 8'h80, 1);
		prog.wr(19'h05555, 8'hAA, 1);
		prog.wr(19'h02AAA, 8'h55, 1);
		prog.wr(19'h05555, 8'h10, 1);
		chk(OP_KIND, OP_CHIP);
		done_op;
		prog.wr(19'h05555, 8'hAA, 0);
		prog.wr(19'h02AAA, 8'h55, 1);
		prog.wr(19'h05555, 8'hA0, 1);
		prog.wr(19'h01234, 8'h5A, 1);
		chk(BUSY, 0);
	endtask : t_chip
	task t_id;
		unl;
		bw(19'h05555, CMD_ID_ENTRY);
		idle;
		chk(ID_MODE, 1);
		rd(ID_SEL_MANUF);
		chk(READ_DATA, 8'h6B);
		rd(ID_SEL_CONT);
		chk(READ_DATA, 8'h2D);
		rd(ID_SEL_DEVICE);
		chk(READ_DATA, 8'h4E);
		rd(2'h2);
		chk(READ_DATA, 8'h00);
		bw(19'h70000, CMD_ID_EXIT);
		idle;
		chk(ID_MODE, 0);
		unl;
		bw(19'h05555, CMD_ID_ENTRY);
		idle;
		chk(ID_MODE, 1);
		unl;
		bw(19'h05555, CMD_ID_EXIT);
		idle;
		chk(ID_MODE, 0);
	endtask : t_id
	task t_abort;
		bw(19'h05555, 8'hAA);
		bw(19'h02AAA, 8'h77);
		unl;
		bw(19'h05555, CMD_PROGRAM);
		bw(19'h00042, 8'h99);
		idle;
		chk(OP_START, 1);
		done_op;
		BUS_IN_RANGE = 1'b0;
		unl;
		BUS_IN_RANGE = 1'b1;
		bw(19'h15555, CMD_PROGRAM);
		bw(19'h00042, 8'h99);
		idle;
		chk(BUSY, 0);
		bw(19'h75555, 8'hAA);
		bw(19'h62AAA, 8'h55);
		bw(19'h15555, CMD_PROGRAM);
		bw(19'h00043, 8'h98);
		idle;
		chk(OP_START, 1);
		done_op;
	endtask : t_abort
	task t_reset;
		unl;
		idle;
		NRST = 1'b0;
		repeat (2) @(posedge CLOCK);
		#1 NRST = 1'b1;
		bw(19'h05555, CMD_PROGRAM);
		bw(19'h00044, 8'h11);
		idle;
		chk(BUSY, 0);
	endtask : t_reset
	initial begin
		repeat (5000) @(posedge CLOCK);
		err_count++;
		wrap_up;
	end
	initial begin
		{NRST, BUS_WR, RD, OP_DONE, RD_SEL} = '0;
		BUS_IN_RANGE = 1'b1;
		{BUS_ADDR, BUS_DATA} = '0;
		ARRAY_DATA = 8'h3C;
		repeat (4) @(posedge CLOCK);
		#1 NRST = 1'b1;
		repeat (1000) @(posedge CLOCK);
		chk(BUSY, 0);
		t_program;
		t_erase;
		t_chip;
		t_id;
		t_abort;
		t_reset;
		wrap_up;
	end
endmodule : flash_write_unlock_sequencer_bench
